// ===== rtl/lmu_core.sv
// load/move instruction unit: decode and execution of the data-move family
// assumes: the fetch side presents all words of an instruction at once with
// the address of its first word; the data bus acknowledges every request
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - plain move is word; suffixes pick byte/half
// - stores keep only low bits that fit
// - memory loads zero- or sign-extend per variant
// - load and word-store immediates are sign-extended
// - pre-decrement first, then use new address
// - post-increment uses old address, then bumps
// - address updates never touch flags
// - memory source sets memory-zero flag from value
// - register/immediate source leaves memory-zero flag
// - nibble 3 loads sign-extended byte immediate
// - upper byte 44 copies register to register
// - 12 indirect word load, 13 with increment
// - 49 offset load extension from word1 top bits
// - 5 with 11 loads word at frame+offset
// - 452 loads 32-bit immediate from two words
// - 034 short direct load, 03C long direct
// - 09C byte immediate from low byte only
// - 097 stores sign-extended halfword immediate as word
// - condition store writes 1 if true, else 0
// - condition store and sign fill keep flags
// - sign fill writes all ones or zeros
// - sign fill is 453 plus destination register
module lmu_core #(
	parameter int unsigned FP_INDEX = 14
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire lmu_pkg::lmu_instr_s instr,
	input wire logic [31:0] pc,
	output logic done,
	output logic illegal,
	output logic [1:0] words,
	output lmu_pkg::lmu_mreq_s mreq,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);

	if (FP_INDEX > 15) begin : g_bad_fp
		$error("FP_INDEX must name one of the 16 registers");
	end

	localparam logic [3:0] FP_REG = 4'(FP_INDEX);

	// sign-extend helpers
	function automatic logic [31:0] sx(input logic [31:0] v, input int w);
		logic [31:0] r;
		r = v;
		for (int k = 0; k < 32; k++) begin
			if (k >= w) begin
				r[k] = v[w-1];
			end
		end
		return r;
	endfunction

	// address step per access size
	function automatic logic [31:0] step_of(input lmu_pkg::lmu_size_e s);
		case (s)
			lmu_pkg::LMU_SZ_B: return 32'h0000_0001;
			lmu_pkg::LMU_SZ_H: return 32'h0000_0002;
			default: return 32'h0000_0004;
		endcase
	endfunction

	// keep the bits that fit the access size
	function automatic logic [31:0] trunc(input logic [31:0] v,
		input lmu_pkg::lmu_size_e s);
		case (s)
			lmu_pkg::LMU_SZ_B: return {24'h000000, v[7:0]};
			lmu_pkg::LMU_SZ_H: return {16'h0000, v[15:0]};
			default: return v;
		endcase
	endfunction

	// widen a loaded value to 32 bits
	function automatic logic [31:0] widen(input logic [31:0] v,
		input lmu_pkg::lmu_size_e s, input logic sext);
		logic [31:0] t;
		t = trunc(v, s);
		if (sext && s == lmu_pkg::LMU_SZ_B) begin
			t = sx(t, 8);
		end else if (sext && s == lmu_pkg::LMU_SZ_H) begin
			t = sx(t, 16);
		end
		return t;
	endfunction

	// size from the half bit of a two-bit extension code: msb signed, lsb half
	function automatic lmu_pkg::lmu_size_e ext_size(input logic half);
		return half ? lmu_pkg::LMU_SZ_H : lmu_pkg::LMU_SZ_B;
	endfunction

	// condition field evaluation against the flags
	function automatic logic cond_true(input logic [3:0] c,
		input logic [7:0] f);
		logic cy;
		logic z;
		logic s;
		logic v;
		cy = f[lmu_pkg::FLAG_C];
		z = f[lmu_pkg::FLAG_Z];
		s = f[lmu_pkg::FLAG_S];
		v = f[lmu_pkg::FLAG_V];
		case (c)
			4'h0: return 1'b0;
			4'h1: return s ^ v;
			4'h2: return z | (s ^ v);
			4'h3: return cy | z;
			4'h4: return v;
			4'h5: return s;
			4'h6: return z;
			4'h7: return cy;
			4'h8: return 1'b1;
			4'h9: return ~(s ^ v);
			4'hA: return ~(z | (s ^ v));
			4'hB: return ~(cy | z);
			4'hC: return ~v;
			4'hD: return ~s;
			4'hE: return ~z;
			default: return ~cy;
		endcase
	endfunction

	// instruction decode
	function automatic lmu_pkg::lmu_dec_s decode(input lmu_pkg::lmu_instr_s i);
		lmu_pkg::lmu_dec_s d;
		logic [2:0] f;
		d = '0;
		d.op = lmu_pkg::LMU_OP_BAD;
		d.size = lmu_pkg::LMU_SZ_W;
		d.mode = lmu_pkg::LMU_AM_IND;
		d.nwords = 2'd1;
		d.dreg = i.w0[3:0];
		d.sreg = i.w0[7:4];
		d.areg = i.w0[7:4];
		d.cond = i.w0[7:4];
		f = i.w0[6:4];
		casez (i.w0[15:8])
			8'h3?: begin
				d.op = lmu_pkg::LMU_OP_LDI;
				d.dreg = i.w0[11:8];
				d.imm = sx({24'h000000, i.w0[7:0]}, 8);
			end
			8'h44: d.op = lmu_pkg::LMU_OP_COPY;
			8'h45: begin
				if (i.w0[7:4] == 4'h2) begin
					d.op = lmu_pkg::LMU_OP_LDI;
					d.imm = {i.w1, i.w2};
					d.nwords = 2'd3;
				end else if (i.w0[7:4] == 4'h3) begin
					d.op = lmu_pkg::LMU_OP_SFILL;
				end else if (i.w0[7:5] == 3'b000) begin
					d.op = lmu_pkg::LMU_OP_LDI;
					d.imm = sx({15'h0000, i.w0[4], i.w1}, 17);
					d.nwords = 2'd2;
				end
			end
			8'h01: d.op = lmu_pkg::LMU_OP_CSTORE;
			8'h00: begin
				if (i.w0[7:4] == 4'h2 || i.w0[7:4] == 4'h3) begin
					d.op = lmu_pkg::LMU_OP_LOAD;
					d.mode = lmu_pkg::LMU_AM_PC;
					d.imm = sx({18'h00000, i.w1[13:0]}, 14);
					d.nwords = 2'd2;
					if (i.w0[4]) begin
						d.size = ext_size(i.w1[14]);
						d.sext = i.w1[15];
					end
				end
			end
			8'h48, 8'h49: begin
				d.op = lmu_pkg::LMU_OP_LOAD;
				d.mode = lmu_pkg::LMU_AM_BASE;
				d.imm = sx({18'h00000, i.w1[13:0]}, 14);
				d.nwords = 2'd2;
				if (i.w0[8]) begin
					d.size = ext_size(i.w1[14]);
					d.sext = i.w1[15];
				end
			end
			8'h4A, 8'h4B: begin
				d.op = lmu_pkg::LMU_OP_STORE;
				d.mode = lmu_pkg::LMU_AM_BASE;
				d.areg = i.w0[3:0];
				d.imm = sx({18'h00000, i.w1[13:0]}, 14);
				d.nwords = 2'd2;
				if (i.w0[8]) begin
					d.size = ext_size(i.w1[14]);
				end
			end
			8'h5?, 8'h6?: begin
				d.mode = lmu_pkg::LMU_AM_BASE;
				d.areg = FP_REG;
				d.sreg = i.w0[3:0];
				d.imm = sx({26'h0000000, i.w0[9:4]}, 6);
				if (i.w0[13]) begin
					d.op = lmu_pkg::LMU_OP_LOAD;
					d.size = ext_size(i.w0[10]);
					d.sext = i.w0[11];
				end else if (i.w0[11:10] == 2'b11) begin
					d.op = lmu_pkg::LMU_OP_LOAD;
				end else begin
					d.op = lmu_pkg::LMU_OP_STORE;
					if (i.w0[11:10] != 2'b10) begin
						d.size = ext_size(i.w0[10]);
					end
				end
			end
			8'h03: begin
				d.mode = lmu_pkg::LMU_AM_ABS;
				d.sreg = i.w0[3:0];
				if (i.w0[7]) begin
					d.imm = {i.w1, i.w2};
					d.nwords = 2'd3;
				end else begin
					d.imm = sx({16'h0000, i.w1}, 16);
					d.nwords = 2'd2;
				end
				d.op = (f <= 3'd4) ? lmu_pkg::LMU_OP_LOAD : lmu_pkg::LMU_OP_STORE;
				d.sext = (f == 3'd1) || (f == 3'd3);
				if (f == 3'd0 || f == 3'd1 || f == 3'd5) begin
					d.size = lmu_pkg::LMU_SZ_B;
				end else if (f == 3'd2 || f == 3'd3 || f == 3'd6) begin
					d.size = lmu_pkg::LMU_SZ_H;
				end
			end
			8'h09: begin
				d.op = lmu_pkg::LMU_OP_STORE;
				d.use_imm = 1'b1;
				d.areg = i.w0[3:0];
				d.nwords = 2'd2;
				case (i.w0[7:4])
					4'h4, 4'h5, 4'hC: begin
						d.size = lmu_pkg::LMU_SZ_B;
						d.imm = {24'h000000, i.w1[7:0]};
					end
					4'h6, 4'h8, 4'hA: begin
						d.size = lmu_pkg::LMU_SZ_H;
						d.imm = {16'h0000, i.w1};
					end
					4'h7, 4'h9, 4'hB: d.imm = sx({16'h0000, i.w1}, 16);
					4'hD, 4'hE, 4'hF: begin
						d.imm = {i.w1, i.w2};
						d.nwords = 2'd3;
					end
					default: d.op = lmu_pkg::LMU_OP_BAD;
				endcase
				case (i.w0[7:4])
					4'h4, 4'h8, 4'h9, 4'hE: d.mode = lmu_pkg::LMU_AM_PRE;
					4'h5, 4'hA, 4'hB, 4'hF: d.mode = lmu_pkg::LMU_AM_POST;
					default: d.mode = lmu_pkg::LMU_AM_IND;
				endcase
			end
			8'h0B, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h14, 8'h15, 8'h16, 8'h17: begin
				d.op = lmu_pkg::LMU_OP_STORE;
				d.areg = i.w0[3:0];
				if (i.w0[15:8] == 8'h0E || i.w0[15:8] == 8'h14 ||
					i.w0[15:8] == 8'h15) begin
					d.size = lmu_pkg::LMU_SZ_B;
				end else if (i.w0[15:8] == 8'h0F || i.w0[15:8] == 8'h16 ||
					i.w0[15:8] == 8'h17) begin
					d.size = lmu_pkg::LMU_SZ_H;
				end
				if (i.w0[12] && !i.w0[8]) begin
					d.mode = lmu_pkg::LMU_AM_PRE;
				end else if (i.w0[12]) begin
					d.mode = lmu_pkg::LMU_AM_POST;
				end
			end
			8'h12, 8'h13, 8'b0001_1???: begin
				d.op = lmu_pkg::LMU_OP_LOAD;
				d.mode = i.w0[8] ? lmu_pkg::LMU_AM_POST : lmu_pkg::LMU_AM_IND;
				if (i.w0[11]) begin
					d.size = ext_size(i.w0[9]);
					d.sext = i.w0[10];
				end
			end
			default: d.op = lmu_pkg::LMU_OP_BAD;
		endcase
		return d;
	endfunction

	lmu_pkg::lmu_state_e state_q;
	logic [31:0] gpr_q [16];
	logic [7:0] flags_q;
	lmu_pkg::lmu_dec_s dec;
	logic take;
	logic [31:0] abase;
	logic [31:0] addr_d;
	logic [31:0] sdata;
	logic is_mem;
	logic upd_areg;
	logic [3:0] pend_dreg_q;
	lmu_pkg::lmu_size_e pend_size_q;
	logic pend_sext_q;
	logic pend_load_q;
	logic ill_last_q;
	logic load_done;
	logic [31:0] load_val;

	// request handshake and decode of the presented instruction
	assign instr_ready = (state_q == lmu_pkg::LMU_ST_IDLE);
	assign take = instr_valid && instr_ready;
	assign dec = decode(instr);
	assign is_mem = (dec.op == lmu_pkg::LMU_OP_LOAD) ||
		(dec.op == lmu_pkg::LMU_OP_STORE);
	assign upd_areg = is_mem && (dec.mode == lmu_pkg::LMU_AM_PRE ||
		dec.mode == lmu_pkg::LMU_AM_POST);
	assign load_done = (state_q == lmu_pkg::LMU_ST_MEM) && mem_ack &&
		pend_load_q;
	assign load_val = widen(mem_rdata, pend_size_q, pend_sext_q);

	// effective address formation
	always_comb begin
		abase = gpr_q[dec.areg];
		case (dec.mode)
			lmu_pkg::LMU_AM_PRE: addr_d = abase - step_of(dec.size);
			lmu_pkg::LMU_AM_POST: addr_d = abase;
			lmu_pkg::LMU_AM_ABS: addr_d = dec.imm;
			lmu_pkg::LMU_AM_BASE: addr_d = abase + dec.imm;
			lmu_pkg::LMU_AM_PC: addr_d = pc + dec.imm;
			default: addr_d = abase;
		endcase
		sdata = trunc(dec.use_imm ? dec.imm : gpr_q[dec.sreg], dec.size);
	end

	// sequencing: busy from a taken memory instruction until its access is acknowledged
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= lmu_pkg::LMU_ST_IDLE;
		end else if (take && is_mem) begin
			state_q <= lmu_pkg::LMU_ST_MEM;
		end else if (state_q == lmu_pkg::LMU_ST_MEM && mem_ack) begin
			state_q <= lmu_pkg::LMU_ST_IDLE;
		end
	end

	// memory request held until acknowledged
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mreq <= '0;
			pend_dreg_q <= 4'h0;
			pend_size_q <= lmu_pkg::LMU_SZ_W;
			pend_sext_q <= 1'b0;
			pend_load_q <= 1'b0;
		end else if (take && is_mem) begin
			mreq.req <= 1'b1;
			mreq.we <= (dec.op == lmu_pkg::LMU_OP_STORE);
			mreq.size <= dec.size;
			mreq.addr <= addr_d;
			mreq.wdata <= (dec.op == lmu_pkg::LMU_OP_STORE) ? sdata : 32'h0;
			pend_dreg_q <= dec.dreg;
			pend_size_q <= dec.size;
			pend_sext_q <= dec.sext;
			pend_load_q <= (dec.op == lmu_pkg::LMU_OP_LOAD);
		end else if (mem_ack) begin
			mreq.req <= 1'b0;
		end
	end

	// register file: port writes first so that the core wins a clash
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int k = 0; k < 16; k++) begin
				gpr_q[k] <= lmu_pkg::GPR_RST;
			end
		end else begin
			if (reg_wr && !reg_addr[4]) begin
				gpr_q[reg_addr[3:0]] <= reg_wdata;
			end
			if (take && upd_areg) begin
				if (dec.mode == lmu_pkg::LMU_AM_PRE) begin
					gpr_q[dec.areg] <= addr_d;
				end else begin
					gpr_q[dec.areg] <= addr_d + step_of(dec.size);
				end
			end
			if (take) begin
				case (dec.op)
					lmu_pkg::LMU_OP_LDI: gpr_q[dec.dreg] <= dec.imm;
					lmu_pkg::LMU_OP_COPY: gpr_q[dec.dreg] <= gpr_q[dec.sreg];
					lmu_pkg::LMU_OP_CSTORE: gpr_q[dec.dreg] <=
						{31'h00000000, cond_true(dec.cond, flags_q)};
					lmu_pkg::LMU_OP_SFILL: gpr_q[dec.dreg] <=
						{32{flags_q[lmu_pkg::FLAG_S]}};
					default: ;
				endcase
			end
			if (load_done) begin
				gpr_q[pend_dreg_q] <= load_val;
			end
		end
	end

	// flags: port writes load all bits; among instructions only a memory-sourced load moves the memory-zero bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_q <= lmu_pkg::FLAGS_RST;
		end else begin
			if (reg_wr && reg_addr == lmu_pkg::RADDR_FLAGS) begin
				flags_q <= reg_wdata[7:0];
			end
			if (load_done) begin
				flags_q[lmu_pkg::FLAG_B] <= (load_val == 32'h0);
			end
		end
	end

	// completion pulse, illegal marker and instruction length
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done <= 1'b0;
			illegal <= 1'b0;
			words <= 2'd0;
			ill_last_q <= 1'b0;
		end else begin
			done <= (take && !is_mem) ||
				(state_q == lmu_pkg::LMU_ST_MEM && mem_ack);
			illegal <= take && (dec.op == lmu_pkg::LMU_OP_BAD);
			if (take) begin
				words <= dec.nwords;
				ill_last_q <= (dec.op == lmu_pkg::LMU_OP_BAD);
			end
		end
	end

	// register port read, answered one cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			if (!reg_addr[4]) begin
				reg_rdata <= gpr_q[reg_addr[3:0]];
			end else if (reg_addr == lmu_pkg::RADDR_FLAGS) begin
				reg_rdata <= {24'h000000, flags_q};
			end else if (reg_addr == lmu_pkg::RADDR_STATUS) begin
				reg_rdata <= {30'h00000000, ill_last_q,
					state_q == lmu_pkg::LMU_ST_MEM};
			end else begin
				reg_rdata <= 32'h0;
			end
		end else begin
			reg_rdata <= 32'h0;
		end
	end

endmodule // lmu_core

`default_nettype wire

// ===== rtl/lmu_pkg.sv
// shared types and constants for the load/move instruction unit
// assumes: one 32-bit core clock, 16-bit instruction words, 16 registers
package lmu_pkg;

	// access sizes of a transfer
	typedef enum logic [1:0] {
		LMU_SZ_B = 2'b00,
		LMU_SZ_H = 2'b01,
		LMU_SZ_W = 2'b10
	} lmu_size_e;

	// what the decoded instruction does
	typedef enum logic [2:0] {
		LMU_OP_BAD    = 3'b000,
		LMU_OP_LDI    = 3'b001,
		LMU_OP_COPY   = 3'b010,
		LMU_OP_LOAD   = 3'b011,
		LMU_OP_STORE  = 3'b100,
		LMU_OP_CSTORE = 3'b101,
		LMU_OP_SFILL  = 3'b110
	} lmu_op_e;

	// how the memory address is formed
	typedef enum logic [2:0] {
		LMU_AM_IND  = 3'b000,
		LMU_AM_PRE  = 3'b001,
		LMU_AM_POST = 3'b010,
		LMU_AM_ABS  = 3'b011,
		LMU_AM_BASE = 3'b100,
		LMU_AM_PC   = 3'b101
	} lmu_mode_e;

	// unit state
	typedef enum logic [0:0] {
		LMU_ST_IDLE = 1'b0,
		LMU_ST_MEM  = 1'b1
	} lmu_state_e;

	// up to three instruction words as fetched
	typedef struct packed {
		logic [15:0] w0;
		logic [15:0] w1;
		logic [15:0] w2;
	} lmu_instr_s;

	// decoded instruction
	typedef struct packed {
		lmu_op_e op;
		lmu_size_e size;
		logic sext;
		lmu_mode_e mode;
		logic [3:0] areg;
		logic [3:0] dreg;
		logic [3:0] sreg;
		logic use_imm;
		logic [31:0] imm;
		logic [3:0] cond;
		logic [1:0] nwords;
	} lmu_dec_s;

	// memory request toward the data bus
	typedef struct packed {
		logic req;
		logic we;
		lmu_size_e size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} lmu_mreq_s;

	// flag bit positions
	localparam int unsigned FLAG_C = 7;
	localparam int unsigned FLAG_Z = 6;
	localparam int unsigned FLAG_S = 5;
	localparam int unsigned FLAG_V = 4;
	localparam int unsigned FLAG_B = 3;

	// reset values
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [31:0] GPR_RST = 32'h0000_0000;

	// register port map: 0..15 general registers, then flags and status
	localparam logic [4:0] RADDR_FLAGS = 5'h10;
	localparam logic [4:0] RADDR_STATUS = 5'h11;
	localparam int unsigned STAT_BUSY = 0;
	localparam int unsigned STAT_ILL = 1;

endpackage

// ===== tb/lmu_core_sva.sv
// checker for lmu_core decode and memory request timing
// assumes: bound to lmu_core, one clock domain, reset active high
`timescale 1ns/10ps
`default_nettype none

module lmu_core_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire lmu_pkg::lmu_instr_s instr,
	input wire logic [31:0] pc,
	input wire logic done,
	input wire logic illegal,
	input wire logic [1:0] words,
	input wire lmu_pkg::lmu_mreq_s mreq,
	input wire logic mem_ack
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic tk;

	// instruction taken at this edge
	assign tk = instr_valid && instr_ready;

	// decode and request properties
	property p_ldi;
		tk && instr.w0[15:12] == 4'h3 |=> done && !illegal && words == 2'h1;
	endproperty
	a_ldi: assert property (p_ldi)
		else $error("byte immediate load not done in one word");
	property p_copy;
		tk && instr.w0[15:8] == 8'h44 |=> done && !mreq.req && words == 2'h1;
	endproperty
	a_copy: assert property (p_copy)
		else $error("register copy misdecoded");
	property p_ind;
		tk && instr.w0[15:9] == 7'h09 |=> mreq.req && !mreq.we
			&& mreq.size == lmu_pkg::LMU_SZ_W;
	endproperty
	a_ind: assert property (p_ind)
		else $error("indirect word load request wrong");
	property p_fp;
		tk && instr.w0[15:10] == 6'h17 |=> mreq.req && !mreq.we
			&& mreq.size == lmu_pkg::LMU_SZ_W;
	endproperty
	a_fp: assert property (p_fp)
		else $error("frame load request wrong");
	property p_imm;
		tk && instr.w0[15:4] == 12'h452 |=> done && words == 2'h3;
	endproperty
	a_imm: assert property (p_imm)
		else $error("word immediate load length wrong");
	property p_dir;
		tk && instr.w0[15:4] == 12'h034 |=> mreq.req
			&& mreq.addr == {{16{$past(instr.w1[15])}}, $past(instr.w1)};
	endproperty
	a_dir: assert property (p_dir)
		else $error("short direct address wrong");
	property p_pcr;
		tk && instr.w0[15:4] == 12'h003 |=> mreq.req && mreq.addr ==
			$past(pc) + {{18{$past(instr.w1[13])}}, $past(instr.w1[13:0])};
	endproperty
	a_pcr: assert property (p_pcr)
		else $error("pc relative address wrong");
	property p_b17;
		tk && instr.w0[15:4] == 12'h09C |=> mreq.we
			&& mreq.size == lmu_pkg::LMU_SZ_B
			&& mreq.wdata == {24'h0, $past(instr.w1[7:0])};
	endproperty
	a_b17: assert property (p_b17)
		else $error("byte immediate store data wrong");
	property p_s18;
		tk && instr.w0[15:4] == 12'h097 |=> mreq.we
			&& mreq.size == lmu_pkg::LMU_SZ_W
			&& mreq.wdata == {{16{$past(instr.w1[15])}}, $past(instr.w1)};
	endproperty
	a_s18: assert property (p_s18)
		else $error("halfword immediate store not extended");
	property p_fill;
		tk && instr.w0[15:4] == 12'h453 |=> done && !mreq.req && !illegal;
	endproperty
	a_fill: assert property (p_fill)
		else $error("sign fill misdecoded");

	// main scenarios reached
	c_mem: cover property (mreq.req && mem_ack);
	c_ill: cover property (illegal);
	c_w3: cover property (done && words == 2'h3);
endmodule // lmu_core_sva

bind lmu_core lmu_core_sva u_sva (
	.clk(clk),
	.rst(rst),
	.instr_valid(instr_valid),
	.instr_ready(instr_ready),
	.instr(instr),
	.pc(pc),
	.done(done),
	.illegal(illegal),
	.words(words),
	.mreq(mreq),
	.mem_ack(mem_ack)
);

`default_nettype wire

// ===== tb/load_move_instruction_unit_tb.sv
// self-checking bench for lmu_core: instruction, memory and register port
// assumes: package and core compiled first, checker bound to the core
`timescale 1ns/10ps
`default_nettype none

module load_move_instruction_unit_tb;
	logic clk = 0, rst = 1, instr_valid = 0, mem_ack = 0;
	logic reg_wr = 0, reg_rd = 0, instr_ready, done, illegal;
	lmu_pkg::lmu_instr_s instr = '0;
	logic [31:0] pc = '0, mem_rdata = '0, reg_wdata = '0, a, rdat;
	logic [4:0] reg_addr = '0;
	logic [1:0] words;
	lmu_pkg::lmu_mreq_s mreq, mq;
	logic [7:0] pat [3] = '{8'h20, 8'h58, 8'hB0};
	logic [15:0] pop [3] = '{16'h13CD, 16'h1FCD, 16'h19CD};
	logic [15:0] dop [3] = '{16'h166D, 16'h106D, 16'h146D};
	logic [1:0] dsz [3] = '{2'h1, 2'h2, 2'h0};
	logic [31:0] dwd [3] = '{32'h0000_8642, 32'hFFFF_8642, 32'h0000_0042};
	int pst [3] = '{4, 2, 1};
	int dst [3] = '{2, 4, 1};
	int error_cnt = 0, total_checks = 0, i;
	logic s, h;

	// 40 MHz clock
	always #12.5 clk = ~clk;

	lmu_core u_dut (
		.clk(clk), .rst(rst), .instr_valid(instr_valid),
		.instr_ready(instr_ready), .instr(instr), .pc(pc), .done(done),
		.illegal(illegal), .words(words), .mreq(mreq), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdat)
	);

	// compare and count
	task chk(input string n, input logic [67:0] v, input logic [67:0] e);
		total_checks++;
		if (v !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", n, e, v);
		end
	endtask

	// expected condition-store result from the flag bits
	function automatic logic [31:0] cc_exp(input logic [3:0] c,
		input logic [7:0] f);
		logic cy, z, sg, v, r;
		cy = f[lmu_pkg::FLAG_C];
		z = f[lmu_pkg::FLAG_Z];
		sg = f[lmu_pkg::FLAG_S];
		v = f[lmu_pkg::FLAG_V];
		case (c[2:0])
			3'h0: r = 1'b0;
			3'h1: r = sg ^ v;
			3'h2: r = z | (sg ^ v);
			3'h3: r = cy | z;
			3'h4: r = v;
			3'h5: r = sg;
			3'h6: r = z;
			default: r = cy;
		endcase
		return {31'h0, r ^ c[3]};
	endfunction

	// one-cycle register port write
	task wr(input logic [4:0] ad, input logic [31:0] d);
		@(posedge clk) reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge clk) reg_wr <= 1'b0;
	endtask

	// register port read, data one cycle later
	task rchk(input string n, input logic [4:0] ad, input logic [31:0] e);
		@(posedge clk) reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk) reg_rd <= 1'b0;
		#1 chk(n, rdat, e);
	endtask

	// issue one instruction, answer its memory access with d
	task ex(input logic [15:0] w0, w1, w2, input logic [31:0] d);
		@(posedge clk) instr_valid <= 1'b1;
		instr <= {w0, w1, w2};
		@(posedge clk) instr_valid <= 1'b0;
		#1 mq = '0;
		if (mreq.req) begin
			mq = mreq;
			chk("busy", instr_ready, 1'b0);
			@(posedge clk) mem_ack <= 1'b1;
			mem_rdata <= d;
			@(posedge clk) mem_ack <= 1'b0;
			mem_rdata <= ~d;
			#1;
		end
		chk("done", done, 1'b1);
		chk("ready", instr_ready, 1'b1);
	endtask

	// captured memory request against expectation
	task mchk(input logic we, input logic [1:0] sz, input logic [31:0] ad, wd);
		chk("mreq", {mq.req, mq.we, mq.size, mq.addr, we ? mq.wdata : 32'h0},
			{1'b1, we, sz, ad, wd});
	endtask

	// closing report
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rchk("flags", 5'h10, 32'h0);
		wr(5'h1F, 32'h5A5A_5A5A);
		rchk("unmapped", 5'h1F, 32'h0);
		ex(16'h3D34, '0, '0, '0);
		chk("words", words, 2'h1);
		rchk("r13", 5'h0D, 32'h0000_0034);
		ex(16'h3DFC, '0, '0, '0);
		rchk("r13", 5'h0D, 32'hFFFF_FFFC);
		for (i = 0; i < 48; i++) begin
			wr(5'h10, {24'h0, pat[i/16]});
			ex({8'h01, 4'(i), 4'h7}, '0, '0, '0);
			rchk("cstore", 5'h07, cc_exp(4'(i), pat[i/16]));
			rchk("flags", 5'h10, {24'h0, pat[i/16]});
		end
		for (i = 0; i < 2; i++) begin
			wr(5'h10, i ? 32'h28 : 32'hD0);
			ex(16'h453D, '0, '0, '0);
			rchk("fill", 5'h0D, {32{i[0]}});
			rchk("flags", 5'h10, i ? 32'h28 : 32'hD0);
		end
		wr(5'h0C, 32'hA5A5_0F0F);
		wr(5'h10, 32'h08);
		ex(16'h44CD, '0, '0, '0);
		rchk("copy", 5'h0D, 32'hA5A5_0F0F);
		rchk("flags", 5'h10, 32'h08);
		ex(16'h452D, 16'h1234, 16'h5678, '0);
		chk("words", words, 2'h3);
		rchk("word_immediate", 5'h0D, 32'h1234_5678);
		wr(5'h0C, 32'hFFFF_B034);
		wr(5'h10, 32'hF8);
		ex(16'h1CCD, '0, '0, 32'h0000_00FF);
		mchk(1'b0, 2'h0, 32'hFFFF_B034, '0);
		rchk("sb", 5'h0D, 32'hFFFF_FFFF);
		rchk("flags", 5'h10, 32'hF0);
		ex(16'h18CD, '0, '0, 32'h0);
		rchk("flags", 5'h10, 32'hF8);
		wr(5'h0D, 32'hFFFF_B07F);
		for (i = 0; i < 4; i++) begin
			s = i[1];
			h = i[0];
			ex(16'h49DC, {i[1:0], 14'h3FFA}, '0, h ? 32'hF783 : 32'h83);
			mchk(1'b0, {1'b0, h}, 32'hFFFF_B079, '0);
			rchk("ext", 5'h0C, h ? {{16{s}}, 16'hF783} :
				{{24{s}}, 8'h83});
		end
		a = 32'h0000_0100;
		wr(5'h0C, a);
		for (i = 0; i < 3; i++) begin
			ex(pop[i], '0, '0, 32'h1);
			mchk(1'b0, 2'(2 - i), a, '0);
			a = a + pst[i];
			rchk("inc", 5'h0C, a);
		end
		a = 32'hFFFF_DB24;
		wr(5'h0D, a);
		wr(5'h06, 32'hFFFF_8642);
		for (i = 0; i < 3; i++) begin
			ex(dop[i], '0, '0, '0);
			a = a - dst[i];
			mchk(1'b1, dsz[i], a, dwd[i]);
			rchk("dec", 5'h0D, a);
		end
		rchk("flags", 5'h10, 32'hF0);
		wr(5'h0E, 32'hFFFF_B07F);
		ex(16'h5FAC, '0, '0, 32'h1234_5678);
		mchk(1'b0, 2'h2, 32'hFFFF_B079, '0);
		rchk("fp", 5'h0C, 32'h1234_5678);
		@(posedge clk) pc <= 32'h0000_B083;
		ex(16'h003C, 16'hFFF6, '0, 32'h7);
		mchk(1'b0, 2'h1, 32'h0000_B079, '0);
		ex(16'h034C, 16'hB034, '0, 32'h7);
		mchk(1'b0, 2'h2, 32'hFFFF_B034, '0);
		ex(16'h03CC, 16'h0012, 16'h3456, 32'h7);
		mchk(1'b0, 2'h2, 32'h0012_3456, '0);
		ex(16'h09CD, 16'h55AB, '0, '0);
		mchk(1'b1, 2'h0, a, 32'hAB);
		ex(16'h097D, 16'hFFFC, '0, '0);
		mchk(1'b1, 2'h2, a, 32'hFFFF_FFFC);
		ex(16'hFFFF, '0, '0, '0);
		chk("illegal", illegal, 1'b1);
		rchk("status", 5'h11, 32'h2);
		give_verdict();
	end
endmodule // load_move_instruction_unit_tb

`default_nettype wire
